/* File: core/qem_pkg.sv */
// Shared constants, types and code functions of the quadword ECC datapath
package qem_pkg;

  localparam logic [11:0] QEM_REG_DIAG = 12'h000;
  localparam logic [11:0] QEM_REG_STAT = 12'h004;
  localparam logic [11:0] QEM_REG_GEN  = 12'h008;

  localparam logic [1:0]  QEM_CODE_GOOD  = 2'h0;
  localparam logic [1:0]  QEM_CODE_FIXED = 2'h1;
  localparam logic [1:0]  QEM_CODE_SUBST = 2'h2;
  localparam logic [1:0]  QEM_CODE_IO    = 2'h0;

  localparam logic [3:0]  QEM_LANES_ALL  = 4'hF;
  localparam int          QEM_POS_TOP    = 72;

  typedef struct packed {
    logic [63:0] data;
    logic [7:0]  chk;
  } qem_ary_in_t;

  typedef struct packed {
    logic [63:0] data;
    logic [7:0]  data_oe;
    logic [7:0]  chk;
    logic        chk_oe;
  } qem_ary_out_t;

  typedef struct packed {
    logic [3:0]  upper_mask;
    logic [3:0]  lower_mask;
    logic [7:0]  chk;
    logic [63:0] data;
    logic [1:0]  par;
    logic        pend_chk;
    logic        pend_gen;
    logic        fix;
    logic        ue;
    logic [63:0] xmit;
    logic [1:0]  code;
    logic [7:0]  syn;
    logic [7:0]  gen_chk;
    logic [63:0] newd;
    logic [31:0] rdata;
    logic        rpar;
    logic [1:0]  rcode;
    logic        r_oe;
    logic        diag_en;
    logic [7:0]  diag_chk;
    logic [31:0] prdata;
  } qem_state_t;

  localparam qem_state_t QEM_STATE_RST = '0;

  // Hamming position of data bit i, skipping power-of-two slots
  function automatic logic [6:0] qem_pos(input int i);
    int n;
    n = 0;
    qem_pos = '0;
    for (int p = 3; p < QEM_POS_TOP; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (n == i) qem_pos = p[6:0];
        n++;
      end
    end
  endfunction : qem_pos

  function automatic logic [6:0] qem_hamm(input logic [63:0] d);
    qem_hamm = '0;
    for (int i = 0; i < 64; i++) begin
      if (d[i]) qem_hamm = qem_hamm ^ qem_pos(i);
    end
  endfunction : qem_hamm

  // Seven position bits plus an overall parity bit
  function automatic logic [7:0] qem_encode(input logic [63:0] d);
    logic [6:0] h;
    h = qem_hamm(d);
    qem_encode = {(^d) ^ (^h), h};
  endfunction : qem_encode

  // Maps a position syndrome to {hit, data bit index}
  function automatic logic [6:0] qem_index(input logic [6:0] h);
    qem_index = '0;
    for (int i = 0; i < 64; i++) begin
      if (qem_pos(i) == h) qem_index = {1'b1, i[5:0]};
    end
  endfunction : qem_index

endpackage : qem_pkg

/* File: core/qem_datapath.sv */
// Quadword ECC, byte mask and merge datapath of the memory controller
//
// What this block does
// - Masked write drives only the chosen new bytes of the addressed longword
// - Read quadword and check bits are latched, checked, corrected, redriven
// - Transmit mux passes upper or lower longword when read enable is high
// - Diagnostic check bits from a register may replace latched check bits
// - Eight-bit syndrome feeds detector, decoder and integrity code logic
// - Each read is classed good, corrected or substitute, sent with data
// - Single error enables fix; byte and bit lines flip at most one data bit
// - Corrected quad leaves via transmit latch; old check bits stay on bus
// - No error or double error leaves decoder lines low and, on a read, transmit latch undriven
// - One parity bit per longword; sent bit picked by the half select
// - Partial write returns only old bytes that new data does not replace
// - Double error on write withholds new and old bytes; nothing is driven
// - Otherwise merged quad is latched and fresh check bits are driven
// - Full extended write skips the check; check latch stays closed
// - Mask decoded at command issue; first data word mask serves second
// - Mask latched as an upper and a lower four-lane group
// - Half selects route latched mask into keep drives; extended uses both
// - With no write, mask mux picks all ones so every byte is driven on a fix
// - Half selects gate new-byte enables; strobes open receive latches
// - All-ones mask flags whole quad; extended write then selects both
// - Only the two low integrity bits are driven, under read enable
// - Register or boot source read data carries an all-zero mask
`timescale 1ns/1ps

module qem_datapath (
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [31:0]          file_data,
  input  wire logic [7:0]           file_mask,
  input  wire logic                 mask_strobe,
  input  wire logic                 ext_mask_strobe,
  input  wire logic                 ext_write,
  input  wire logic                 new_data_strobe,
  input  wire logic                 upper_strobe_enable,
  input  wire logic                 lower_strobe_enable,
  input  wire logic                 upper_half_write_select,
  input  wire logic                 lower_half_write_select,
  input  wire logic                 check_latch_strobe,
  input  wire logic                 array_data_latch_strobe,
  input  wire logic                 keep_drive_phase,
  input  wire logic                 new_drive_phase,
  input  wire logic                 check_drive_phase,
  input  wire logic                 longword_xmit_enable,
  input  wire logic                 longword_half_select,
  input  wire logic                 parity_half_select,
  input  wire logic                 io_source_drive,
  input  wire logic [31:0]          io_data,
  input  wire qem_pkg::qem_ary_in_t array_in,
  output qem_pkg::qem_ary_out_t     array_out,
  output logic      [31:0]          file_rdata,
  output logic                      file_rparity,
  output logic      [1:0]           integrity_code_out,
  output logic                      file_drive,
  output logic      [3:0]           upper_keep_byte_drive,
  output logic      [3:0]           lower_keep_byte_drive,
  output logic      [3:0]           upper_new_byte_gate,
  output logic      [3:0]           lower_new_byte_gate,
  output logic      [3:0]           upper_new_byte_strobe,
  output logic      [3:0]           lower_new_byte_strobe,
  output logic                      whole_quad_detect,
  output logic                      whole_quad_write,
  output logic                      single_fix_enable,
  output logic                      new_check_drive,
  output logic      [7:0]           check_difference_vector
);

  qem_pkg::qem_state_t s_q;
  qem_pkg::qem_state_t s_d;

  logic        lo_sel;
  logic        up_sel;
  logic        all_lanes_select;
  logic        write_sel;
  logic        chk_latch_en;
  logic [7:0]  chk_used;
  logic [6:0]  hsyn;
  logic [7:0]  syn;
  logic        single;
  logic        double;
  logic [6:0]  fix_idx;
  logic [7:0]  byte_line;
  logic [7:0]  bit_line;
  logic [63:0] flip;
  logic [7:0]  keep;
  logic [7:0]  gate;
  logic [7:0]  bstrobe;
  logic [7:0]  old_oe;
  logic [7:0]  new_oe;
  logic        apb_setup;
  logic        apb_write;
  logic        addr_hit;

  // Mask decode and mux
  assign whole_quad_detect = &{s_q.upper_mask, s_q.lower_mask};
  assign whole_quad_write  = whole_quad_detect & ext_write;
  assign lo_sel    = lower_half_write_select | whole_quad_write;
  assign up_sel    = upper_half_write_select | whole_quad_write;
  assign write_sel = lo_sel | up_sel;
  assign all_lanes_select = ~write_sel;

  // Lanes of the untouched half are all returned, so only the selected
  // half carries the inverted mask.
  assign lower_keep_byte_drive = lo_sel ? ~s_q.lower_mask
                                        : qem_pkg::QEM_LANES_ALL;
  assign upper_keep_byte_drive = up_sel ? ~s_q.upper_mask
                                        : qem_pkg::QEM_LANES_ALL;
  assign keep = {upper_keep_byte_drive, lower_keep_byte_drive};

  assign lower_new_byte_gate = lo_sel ? s_q.lower_mask : 4'h0;
  assign upper_new_byte_gate = up_sel ? s_q.upper_mask : 4'h0;
  assign gate = {upper_new_byte_gate, lower_new_byte_gate};
  assign lower_new_byte_strobe = lower_new_byte_gate
                               & {4{lower_strobe_enable & new_data_strobe}};
  assign upper_new_byte_strobe = upper_new_byte_gate
                               & {4{upper_strobe_enable & new_data_strobe}};
  assign bstrobe = {upper_new_byte_strobe, lower_new_byte_strobe};

  // A full extended write never opens the check latch
  assign chk_latch_en = check_latch_strobe & ~whole_quad_write;

  // Syndrome
  assign chk_used = s_q.diag_en ? s_q.diag_chk : s_q.chk;
  assign hsyn     = qem_pkg::qem_hamm(s_q.data) ^ chk_used[6:0];
  assign syn      = {(^s_q.data) ^ (^chk_used), hsyn};
  assign single   = syn[7];
  assign double   = ~syn[7] & (|hsyn);
  assign fix_idx  = qem_pkg::qem_index(hsyn);

  // A check bit error also reads as single but hits no data line
  always_comb begin
    byte_line = '0;
    bit_line  = '0;
    if (single & fix_idx[6]) begin
      byte_line[fix_idx[5:3]] = 1'b1;
      bit_line[fix_idx[2:0]]  = 1'b1;
    end
  end

  genvar gb;
  genvar gk;
  generate
    for (gb = 0; gb < 8; gb++) begin : g_byte
      for (gk = 0; gk < 8; gk++) begin : g_bit
        assign flip[8*gb+gk] = byte_line[gb] & bit_line[gk];
      end
      // Old bytes go out only corrected on reads, masked on writes
      assign old_oe[gb] = keep_drive_phase & ~s_q.ue & keep[gb]
                        & (write_sel | s_q.fix);
      assign new_oe[gb] = new_drive_phase & ~s_q.ue
                        & gate[gb];
      assign array_out.data[8*gb +: 8] = old_oe[gb] ? s_q.xmit[8*gb +: 8]
                                                    : s_q.newd[8*gb +: 8];
    end
  endgenerate

  assign array_out.data_oe = old_oe | new_oe;
  assign new_check_drive   = check_drive_phase & ~s_q.ue;
  assign array_out.chk_oe  = new_check_drive;
  assign array_out.chk     = s_q.gen_chk;

  // APB, zero wait state
  assign apb_setup = psel & ~penable;
  assign apb_write = psel & penable & pwrite;
  assign addr_hit  = (paddr == qem_pkg::QEM_REG_DIAG)
                   | (paddr == qem_pkg::QEM_REG_STAT)
                   | (paddr == qem_pkg::QEM_REG_GEN);
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~addr_hit;
  assign prdata    = s_q.prdata;

  always_comb begin
    s_d = s_q;
    s_d.pend_chk = 1'b0;
    s_d.pend_gen = 1'b0;
    if (mask_strobe) begin
      s_d.upper_mask = file_mask[7:4];
      s_d.lower_mask = file_mask[3:0];
      s_d.fix  = 1'b0;
      s_d.ue   = 1'b0;
      s_d.code = qem_pkg::QEM_CODE_GOOD;
    end else if (ext_mask_strobe) begin
      s_d.upper_mask = file_mask[3:0];
      s_d.lower_mask = file_mask[3:0];
    end
    for (int b = 0; b < 8; b++) begin
      if (bstrobe[b]) begin
        s_d.newd[8*b +: 8] = file_data[8*(b%4) +: 8];
      end
    end
    if (chk_latch_en) begin
      s_d.chk = array_in.chk;
    end
    if (array_data_latch_strobe) begin
      s_d.data = array_in.data;
      s_d.par  = {^array_in.data[63:32], ^array_in.data[31:0]};
      s_d.pend_chk = chk_latch_en;
      s_d.pend_gen = ~chk_latch_en;
    end
    if (s_q.pend_chk) begin
      s_d.syn  = syn;
      s_d.fix  = single;
      s_d.ue   = double;
      // Transmit latch loads the latched quad on every check, with any flip applied
      s_d.xmit = s_q.data ^ flip;
      s_d.code = double ? qem_pkg::QEM_CODE_SUBST
               : single ? qem_pkg::QEM_CODE_FIXED
               : qem_pkg::QEM_CODE_GOOD;
    end
    if (s_q.pend_gen) begin
      s_d.gen_chk = qem_pkg::qem_encode(s_q.data);
    end
    s_d.r_oe = longword_xmit_enable | io_source_drive;
    if (io_source_drive) begin
      s_d.rdata = io_data;
      s_d.rcode = qem_pkg::QEM_CODE_IO;
      s_d.rpar  = ^io_data;
    end else if (longword_xmit_enable) begin
      s_d.rdata = longword_half_select ? array_in.data[31:0]
                                       : array_in.data[63:32];
      s_d.rpar  = parity_half_select ? s_q.par[0] : s_q.par[1];
      s_d.rcode = s_q.code;
    end
    if (apb_write && paddr == qem_pkg::QEM_REG_DIAG) begin
      s_d.diag_en  = pwdata[0];
      s_d.diag_chk = pwdata[15:8];
    end
    if (apb_setup) begin
      unique case (paddr)
        qem_pkg::QEM_REG_DIAG: begin
          s_d.prdata = {16'h0000, s_q.diag_chk, 7'h00, s_q.diag_en};
        end
        qem_pkg::QEM_REG_STAT: begin
          s_d.prdata = {14'h0000, s_q.code, 6'h00, s_q.ue, s_q.fix,
                        s_q.syn};
        end
        qem_pkg::QEM_REG_GEN: begin
          s_d.prdata = {24'h000000, s_q.gen_chk};
        end
        default: begin
          s_d.prdata = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= qem_pkg::QEM_STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign file_rdata         = s_q.rdata;
  assign file_rparity       = s_q.rpar;
  assign integrity_code_out = s_q.rcode;
  assign file_drive         = s_q.r_oe;
  assign single_fix_enable  = s_q.fix;
  assign check_difference_vector = s_q.syn;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_check_latch;
    array_data_latch_strobe && chk_latch_en;
  endsequence

  sequence s_gen_latch;
    array_data_latch_strobe && !chk_latch_en;
  endsequence

  fix_on_single_a: assert property (
    s_check_latch ##1 single |=> single_fix_enable && !s_q.ue)
    else $error("single error did not enable fix");

  subst_on_double_a: assert property (
    s_check_latch ##1 double |=> s_q.code == qem_pkg::QEM_CODE_SUBST)
    else $error("double error not tagged substitute");

  one_bit_flip_a: assert property (
    s_q.pend_chk && single && fix_idx[6] |=> $countones(s_q.xmit ^
      s_q.data) == 1)
    else $error("correction did not flip exactly one bit");

  gen_check_a: assert property (
    s_gen_latch |=> ##1 s_q.gen_chk == qem_pkg::qem_encode(s_q.data))
    else $error("fresh check bits wrong");

  ue_withhold_a: assert property (
    s_q.ue |-> array_out.data_oe == 8'h00 && !array_out.chk_oe)
    else $error("drive during uncorrectable error");

  idle_no_drive_a: assert property (
    keep_drive_phase && !write_sel && !s_q.fix && !new_drive_phase
    |-> array_out.data_oe == 8'h00)
    else $error("transmit latch driven without correction");

  read_lanes_a: assert property (
    all_lanes_select |-> keep == 8'hFF && gate == 8'h00)
    else $error("read mask not all ones");

  whole_quad_a: assert property (
    whole_quad_detect && ext_write |-> gate == 8'hFF && keep == 8'h00)
    else $error("whole quad write lanes wrong");

  no_check_full_a: assert property (
    whole_quad_write && check_latch_strobe |=> $stable(s_q.chk))
    else $error("check latch opened on full write");

  xmit_mux_a: assert property (
    longword_xmit_enable && !io_source_drive
    |=> file_rdata == ($past(longword_half_select)
      ? $past(array_in.data[31:0]) : $past(array_in.data[63:32])))
    else $error("transmit mux picked wrong longword");

  io_zero_mask_a: assert property (
    io_source_drive |=> integrity_code_out == 2'h0 && file_drive)
    else $error("io read mask not zero");

  sequence s_no_error;
    !single && !double;
  endsequence

  clean_read_a: assert property (
    s_check_latch ##1 s_no_error |=> s_q.code == qem_pkg::QEM_CODE_GOOD
      && !single_fix_enable && s_q.xmit == $past(s_q.data))
    else $error("clean read was altered");

  fix_code_a: assert property (
    s_check_latch ##1 single |=> s_q.code == qem_pkg::QEM_CODE_FIXED)
    else $error("single error not tagged corrected");

  fix_drive_a: assert property (
    keep_drive_phase && s_q.fix && !write_sel && !new_drive_phase
    |-> array_out.data_oe == 8'hFF && array_out.data == s_q.xmit)
    else $error("corrected quad not driven");

  par_latch_a: assert property (
    array_data_latch_strobe |=> s_q.par == {^$past(array_in.data[63:32]),
      ^$past(array_in.data[31:0])})
    else $error("longword parity not latched");

  parity_pick_a: assert property (
    longword_xmit_enable && !io_source_drive
    |=> file_rparity == ($past(parity_half_select) ? $past(s_q.par[0])
      : $past(s_q.par[1])))
    else $error("wrong longword parity sent");

  mask_latch_a: assert property (
    mask_strobe |=> {s_q.upper_mask, s_q.lower_mask} == $past(file_mask))
    else $error("mask groups not latched");

  ext_mask_a: assert property (
    ext_mask_strobe && !mask_strobe
    |=> {s_q.upper_mask, s_q.lower_mask} == {2{$past(file_mask[3:0])}})
    else $error("first word mask not reused");

  io_data_a: assert property (
    io_source_drive |=> file_rdata == $past(io_data))
    else $error("io data not passed");

endmodule : qem_datapath

/* File: verification/qem_array_model.sv */
// Array board model facing the datapath's array bus
`timescale 1ns/1ps

module qem_array_model (
  input  wire logic                  clk,
  input  wire logic                  present,
  input  wire logic [63:0]           wdata,
  input  wire logic [7:0]            wchk,
  input  wire qem_pkg::qem_ary_out_t dev,
  output qem_pkg::qem_ary_in_t       bus
);
  logic [71:0] last_q = '0;

  // Device enables win, then present array data; otherwise a line shows the flipped stale value,
  // so a design that samples an undriven bus sees garbage, not old data
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      if (dev.data_oe[b]) bus.data[b*8 +: 8] = dev.data[b*8 +: 8];
      else if (present) bus.data[b*8 +: 8] = wdata[b*8 +: 8];
      else bus.data[b*8 +: 8] = ~last_q[b*8+8 +: 8];
    end
    if (dev.chk_oe) bus.chk = dev.chk;
    else if (present) bus.chk = wchk;
    else bus.chk = ~last_q[7:0];
  end

  always_ff @(posedge clk) begin
    last_q <= bus;
  end
endmodule : qem_array_model

/* File: verification/tb.sv */
// Self-checking bench for the quadword ECC datapath
`timescale 1ns/1ps

module tb;
  typedef struct packed {
    logic [63:0] d;
    logic [71:0] e;
    logic        lo;
    logic        dg;
    logic [1:0]  code;
  } qem_row_t;

  localparam logic [63:0] FQ = 64'h1234_5678_9ABC_DEF0;
  logic clk = '0, srst = '1, psel = '0, penable = '0, pwrite = '0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, file_data = '0, io_data = '0;
  logic [31:0] prdata, file_rdata, r;
  logic pready, pslverr, file_rparity, file_drive, se;
  logic whole_quad_detect, whole_quad_write, single_fix_enable;
  logic new_check_drive;
  logic [7:0] file_mask = '0, wchk = '0, check_difference_vector;
  logic mask_strobe = '0, ext_mask_strobe = '0, ext_write = '0;
  logic new_data_strobe = '0, upper_strobe_enable = '0;
  logic lower_strobe_enable = '0, upper_half_write_select = '0;
  logic lower_half_write_select = '0, check_latch_strobe = '0;
  logic array_data_latch_strobe = '0, keep_drive_phase = '0;
  logic new_drive_phase = '0, check_drive_phase = '0;
  logic longword_xmit_enable = '0, longword_half_select = '0;
  logic parity_half_select = '0, io_source_drive = '0, present = '0;
  logic [1:0] integrity_code_out;
  logic [3:0] upper_keep_byte_drive, lower_keep_byte_drive;
  logic [3:0] upper_new_byte_gate, lower_new_byte_gate;
  logic [3:0] upper_new_byte_strobe, lower_new_byte_strobe;
  logic [63:0] wdata = '0;
  qem_pkg::qem_ary_in_t  array_in;
  qem_pkg::qem_ary_out_t array_out;
  int checks = 0, mismatches = 0;

  qem_row_t rows [6] = '{
    '{64'h0123456789ABCDEF, 72'h0, 1'b1, 1'b0, qem_pkg::QEM_CODE_GOOD},
    '{64'h0123456789ABCDEF, 72'h0, 1'b0, 1'b0, qem_pkg::QEM_CODE_GOOD},
    '{64'hFFFF0000A5A55A5A, 72'h200000000000, 1'b0, 1'b0,
      qem_pkg::QEM_CODE_FIXED},
    '{64'hFFFF0000A5A55A5A, 72'h08, 1'b1, 1'b0, qem_pkg::QEM_CODE_FIXED},
    '{64'h00000000FFFFFFFF, 72'h0F, 1'b1, 1'b1, qem_pkg::QEM_CODE_GOOD},
    '{64'h0F0F0F0F0F0F0F0F, 72'hC0000, 1'b1, 1'b0, qem_pkg::QEM_CODE_SUBST}
  };

  qem_datapath DUT (.*);
  qem_array_model u_array (
    .clk     (clk),
    .present (present),
    .wdata   (wdata),
    .wchk    (wchk),
    .dev     (array_out),
    .bus     (array_in)
  );

  always #5 clk = ~clk;

  task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  // Own encoder, so expectations never lean on the design's functions
  function automatic logic [7:0] enc(input logic [63:0] d);
    logic [6:0] h;
    int         n;
    h = '0;
    n = 0;
    for (int p = 3; n < 64; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (d[n]) h = h ^ p[6:0];
        n++;
      end
    end
    return {^d ^ ^h, h};
  endfunction : enc

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic rd(input qem_row_t w);
    logic [63:0] bd;
    logic [63:0] fd;
    logic [7:0]  bc;
    logic [7:0]  cu;
    logic [7:0]  s;
    logic        fx;
    bd = w.d ^ w.e[71:8];
    bc = enc(w.d) ^ w.e[7:0];
    cu = w.dg ? enc(w.d) : bc;
    s = enc(bd) ^ cu;
    s[7] = ^bd ^ ^cu;
    fx = w.code == qem_pkg::QEM_CODE_FIXED;
    fd = fx ? w.d : bd;
    apb(1'b1, qem_pkg::QEM_REG_DIAG, {16'h0, enc(w.d), 7'h0, w.dg});
    mask_strobe <= 1'b1;
    wdata <= bd;
    wchk <= bc;
    present <= 1'b1;
    @(posedge clk);
    mask_strobe <= 1'b0;
    check_latch_strobe <= 1'b1;
    array_data_latch_strobe <= 1'b1;
    @(posedge clk);
    check_latch_strobe <= 1'b0;
    array_data_latch_strobe <= 1'b0;
    repeat (3) @(posedge clk);
    keep_drive_phase <= 1'b1;
    longword_xmit_enable <= 1'b1;
    longword_half_select <= w.lo;
    parity_half_select <= w.lo;
    #1;
    chk(single_fix_enable, fx);
    chk(check_difference_vector, s);
    chk(array_out.data_oe, fx ? 8'hFF : 8'h00);
    chk(array_out.chk_oe, 1'b0);
    chk({upper_keep_byte_drive, lower_keep_byte_drive}, 8'hFF);
    @(posedge clk);
    keep_drive_phase <= 1'b0;
    longword_xmit_enable <= 1'b0;
    present <= 1'b0;
    #1;
    chk(file_rdata, w.lo ? fd[31:0] : fd[63:32]);
    chk(file_rparity, w.lo ? ^bd[31:0] : ^bd[63:32]);
    chk({file_drive, integrity_code_out}, {1'b1, w.code});
    @(posedge clk);
    apb(1'b0, qem_pkg::QEM_REG_STAT, 32'h0);
    chk(r, {14'h0, w.code, 6'h0, !w.code[0] && w.code[1], fx, s});
  endtask : rd

  task automatic mw(input logic [63:0] od, input logic [71:0] e,
                    input logic [3:0] m, input logic up,
                    input logic [31:0] nd, input logic ue);
    logic [63:0] q;
    q = od;
    for (int b = 0; b < 4; b++)
      if (m[b]) q[(up ? 32 : 0) + b * 8 +: 8] = nd[b*8 +: 8];
    file_mask <= up ? {m, 4'h0} : {4'h0, m};
    mask_strobe <= 1'b1;
    upper_half_write_select <= up;
    lower_half_write_select <= !up;
    upper_strobe_enable <= up;
    lower_strobe_enable <= !up;
    file_data <= nd;
    wdata <= od ^ e[71:8];
    wchk <= enc(od) ^ e[7:0];
    present <= 1'b1;
    @(posedge clk);
    mask_strobe <= 1'b0;
    new_data_strobe <= 1'b1;
    check_latch_strobe <= 1'b1;
    array_data_latch_strobe <= 1'b1;
    #1;
    chk({upper_new_byte_gate, lower_new_byte_gate,
         upper_new_byte_strobe, lower_new_byte_strobe},
        {2{up ? {m, 4'h0} : {4'h0, m}}});
    @(posedge clk);
    new_data_strobe <= 1'b0;
    check_latch_strobe <= 1'b0;
    array_data_latch_strobe <= 1'b0;
    #1;
    chk({upper_keep_byte_drive, lower_keep_byte_drive},
        up ? {~m, 4'hF} : {4'hF, ~m});
    repeat (3) @(posedge clk);
    present <= 1'b0;
    keep_drive_phase <= 1'b1;
    new_drive_phase <= 1'b1;
    #1;
    chk(array_out.data_oe, ue ? 8'h00 : 8'hFF);
    if (!ue) chk(array_out.data, q);
    @(posedge clk);
    array_data_latch_strobe <= 1'b1;
    @(posedge clk);
    array_data_latch_strobe <= 1'b0;
    repeat (2) @(posedge clk);
    keep_drive_phase <= 1'b0;
    new_drive_phase <= 1'b0;
    check_drive_phase <= 1'b1;
    #1;
    chk({new_check_drive, array_out.chk_oe}, {2{!ue}});
    if (!ue) chk(array_out.chk, enc(q));
    @(posedge clk);
    check_drive_phase <= 1'b0;
    upper_half_write_select <= 1'b0;
    lower_half_write_select <= 1'b0;
    upper_strobe_enable <= 1'b0;
    lower_strobe_enable <= 1'b0;
    @(posedge clk);
  endtask : mw

  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    chk({pready, upper_keep_byte_drive, lower_keep_byte_drive,
         array_out.data_oe, array_out.chk_oe, file_drive,
         single_fix_enable}, {1'b1, 8'hFF, 11'h0});
    @(posedge clk);
    apb(1'b1, qem_pkg::QEM_REG_DIAG, 32'h0000AB01);
    apb(1'b0, qem_pkg::QEM_REG_DIAG, 32'h0);
    chk(r, 32'h0000AB01);
    apb(1'b0, 12'h00C, 32'h0);
    chk({se, r}, {1'b1, 32'h0});
    foreach (rows[i]) rd(rows[i]);
    // I/O source wins over the read transmit path
    io_data <= 32'h5A5A_C3C3;
    io_source_drive <= 1'b1;
    longword_xmit_enable <= 1'b1;
    @(posedge clk);
    io_source_drive <= 1'b0;
    longword_xmit_enable <= 1'b0;
    #1;
    chk({file_drive, integrity_code_out, file_rdata},
        {1'b1, qem_pkg::QEM_CODE_IO, 32'h5A5A_C3C3});
    @(posedge clk);
    mw(64'h1122334455667788, 72'h0, 4'h5, 1'b0, 32'hAABBCCDD, 1'b0);
    mw(64'h1122334455667788, 72'h100000, 4'hA, 1'b1, 32'h01234567, 1'b0);
    mw(64'h8877665544332211, 72'h0, 4'hF, 1'b1, 32'h0F1E2D3C, 1'b0);
    mw(64'h8877665544332211, 72'h300, 4'h3, 1'b0, 32'h99999999, 1'b1);
    ext_write <= 1'b1;
    file_mask <= 8'hFF;
    mask_strobe <= 1'b1;
    @(posedge clk);
    mask_strobe <= 1'b0;
    file_mask <= 8'h0F;
    ext_mask_strobe <= 1'b1;
    @(posedge clk);
    ext_mask_strobe <= 1'b0;
    file_data <= FQ[63:32];
    upper_strobe_enable <= 1'b1;
    new_data_strobe <= 1'b1;
    @(posedge clk);
    file_data <= FQ[31:0];
    upper_strobe_enable <= 1'b0;
    lower_strobe_enable <= 1'b1;
    #1;
    chk({whole_quad_detect, whole_quad_write}, 2'h3);
    @(posedge clk);
    new_data_strobe <= 1'b0;
    lower_strobe_enable <= 1'b0;
    upper_half_write_select <= 1'b1;
    lower_half_write_select <= 1'b1;
    new_drive_phase <= 1'b1;
    check_latch_strobe <= 1'b1;
    array_data_latch_strobe <= 1'b1;
    #1;
    chk({array_out.data_oe, array_out.data}, {8'hFF, FQ});
    @(posedge clk);
    check_latch_strobe <= 1'b0;
    array_data_latch_strobe <= 1'b0;
    repeat (2) @(posedge clk);
    new_drive_phase <= 1'b0;
    check_drive_phase <= 1'b1;
    #1;
    chk({single_fix_enable, new_check_drive}, 2'h1);
    chk(array_out.chk, enc(FQ));
    @(posedge clk);
    check_drive_phase <= 1'b0;
    ext_write <= 1'b0;
    upper_half_write_select <= 1'b0;
    lower_half_write_select <= 1'b0;
    // Generated check bits are read-only
    apb(1'b1, qem_pkg::QEM_REG_GEN, 32'hFFFFFFFF);
    apb(1'b0, qem_pkg::QEM_REG_GEN, 32'h0);
    chk(r, {24'h0, enc(FQ)});
    conclude();
  end

  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    conclude();
  end
endmodule : tb
